// *** dv/hvl_fault_regs_tb_top.sv ***
// Purpose: self-checking bench for the fault register bank
// Assumes: reads answer on the edge after the strobe
// Notes: filter count 3 for open, 0 for short
`timescale 1ns/1ps
module hvl_fault_regs_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic mid;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00;
    logic [7:0] rdata, g2, l2, g3, l3;
    logic [2:0] oen, sen, irq, od, sd;
    logic [2:0] fo = 3'h0;
    logic [2:0] fs = 3'h0;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [15:0] ra[6] = '{16'hA048, 16'hA049, 16'hA04C, 16'hA04D, 16'hA046, 16'hA047};
    logic [7:0] rw[6] = '{8'hA5, 8'hFF, 8'h5A, 8'hFF, 8'hCC, 8'hFF};
    logic [7:0] re[6] = '{8'hA5, 8'h9F, 8'h5A, 8'hBF, 8'hC0, 8'h00};
    hvl_fault_regs dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdata), .i_pwm_mid(mid), .i_open_detect(od),
        .i_short_detect(sd), .i_open_filter_count(4'h3), .i_short_filter_count(4'h0),
        .o_ch2_general_config(g2), .o_ch2_led_config(l2), .o_ch3_general_config(g3),
        .o_ch3_led_config(l3), .o_open_detect_enable(oen), .o_short_detect_enable(sen), .o_fault_irq(irq));
    hvl_led_model partner_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_open(fo), .i_short(fs),
        .o_pwm_mid(mid), .o_open_detect(od), .o_short_detect(sd));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic give_verdict();
        if (num_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, e);
    endtask
    task automatic samples(input int n);
        repeat (n) @(posedge clk iff mid);
        repeat (4) @(negedge clk);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        // ----------------------------------------
        // reset values
        // ----------------------------------------
        for (int i = 0; i < 6; i++) begin
            rd_chk(ra[i], 8'h00);
        end
        rd_chk(16'hA04A, 8'h00);
        rd_chk(16'hA04E, 8'h00);
        // ----------------------------------------
        // register rows
        // ----------------------------------------
        for (int i = 0; i < 6; i++) begin
            wr_reg(ra[i], rw[i]);
            rd_chk(ra[i], re[i]);
        end
        chk(g2, 8'hA5);
        chk(l2, 8'h9F);
        chk(g3, 8'h5A);
        chk(l3, 8'hBF);
        // ----------------------------------------
        // faults, flags and enables
        // ----------------------------------------
        wr_reg(16'hA046, 8'h30);
        wr_reg(16'hA04A, 8'h70);
        chk({5'h0, oen}, 8'h03);
        chk({5'h0, sen}, 8'h03);
        @(negedge clk);
        fo = 3'h6;
        fs = 3'h7;
        samples(1);
        rd_chk(16'hA04A, 8'h7F);
        rd_chk(16'hA046, 8'h35);
        rd_chk(16'hA04E, 8'h00);
        chk({5'h0, irq}, 8'h02);
        fo = 3'h0;
        fs = 3'h0;
        samples(1);
        rd_chk(16'hA04A, 8'h73);
        rd_chk(16'hA046, 8'h31);
        wr_reg(16'hA04A, 8'hFD);
        rd_chk(16'hA04A, 8'hF1);
        wr_reg(16'hA04A, 8'h70);
        wr_reg(16'hA046, 8'h30);
        rd_chk(16'hA04A, 8'h70);
        chk({5'h0, irq}, 8'h00);
        // ----------------------------------------
        // filtered open on channel 3
        // ----------------------------------------
        wr_reg(16'hA04E, 8'hA0);
        fo = 3'h4;
        fs = 3'h4;
        samples(2);
        rd_chk(16'hA04E, 8'hA0);
        samples(1);
        rd_chk(16'hA04E, 8'hAA);
        fo = 3'h0;
        samples(1);
        rd_chk(16'hA04E, 8'hAA);
        samples(2);
        rd_chk(16'hA04E, 8'hA2);
        // ----------------------------------------
        // set against clear, then reset mid-run
        // ----------------------------------------
        wr_reg(16'hA046, 8'h20);
        fo = 3'h1;
        @(posedge clk iff mid);
        wr_reg(16'hA046, 8'h20);
        rd_chk(16'hA046, 8'h2A);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk(l3, 8'h00);
        chk(g2, 8'h00);
        rd_chk(16'hA046, 8'h00);
        rd_chk(16'hA04D, 8'h00);
        give_verdict();
    end
endmodule

// *** dv/hvl_led_model.sv ***
// Purpose: led strings and their open/short comparators
// Assumes: pwm period of 8 clocks, midpoint pulse one cycle
// Notes: faults are commanded by the bench
`timescale 1ns/1ps
module hvl_led_model (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // commanded faults
    input wire logic [2:0] i_open,
    input wire logic [2:0] i_short,
    // detector side
    output logic o_pwm_mid,
    output logic [2:0] o_open_detect,
    output logic [2:0] o_short_detect
);
    logic [2:0] phase;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase <= 3'h0;
            o_pwm_mid <= 1'b0;
        end else begin
            phase <= phase + 3'h1;
            o_pwm_mid <= (phase == 3'h3);
        end
    end
    assign o_open_detect = i_open;
    assign o_short_detect = i_short;
endmodule

// *** hdl/hvl_fault_filter.sv ***
// Purpose: up/down fault filter for one detector of one channel
// Assumes: i_sample pulses once per pwm period at its midpoint
// Notes: o_set pulses on each sample that leaves the filtered fault standing
`timescale 1ns/1ps
module hvl_fault_filter (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_sample,
    input wire logic i_raw,
    input wire logic i_detect_enable,
    input wire logic i_filter_enable,
    input wire logic [3:0] i_count,
    // result
    output logic o_live,
    output logic o_set
);
    hvl_pkg::hvl_filt_state_type state;
    hvl_pkg::hvl_filt_state_type next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    // ----------------------------------------------------------------
    // next count and state
    // ----------------------------------------------------------------
    always_comb begin
        next_cnt = cnt;
        next_state = state;
        if (!i_detect_enable) begin
            next_cnt = hvl_pkg::FILT_CNT_RESET;
            next_state = hvl_pkg::FLT_CLEAR;
        end else if (i_sample) begin
            if (!i_filter_enable || i_count == 4'h0) begin
                next_cnt = hvl_pkg::FILT_CNT_RESET;
                next_state = i_raw ? hvl_pkg::FLT_FAULT : hvl_pkg::FLT_CLEAR;
            end else begin
                if (i_raw && cnt < i_count) begin
                    next_cnt = cnt + 4'h1;
                end else if (!i_raw && cnt != 4'h0) begin
                    next_cnt = cnt - 4'h1;
                end
                case (state)
                    hvl_pkg::FLT_CLEAR: begin
                        if (next_cnt >= i_count) begin
                            next_state = hvl_pkg::FLT_FAULT;
                        end
                    end
                    hvl_pkg::FLT_FAULT: begin
                        if (next_cnt == 4'h0) begin
                            next_state = hvl_pkg::FLT_CLEAR;
                        end
                    end
                    default: begin
                        next_state = hvl_pkg::FLT_CLEAR;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= hvl_pkg::FLT_CLEAR;
            cnt <= hvl_pkg::FILT_CNT_RESET;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_set <= 1'b0;
        end else begin
            o_set <= i_sample && i_detect_enable && (next_state == hvl_pkg::FLT_FAULT);
        end
    end

    assign o_live = (state == hvl_pkg::FLT_FAULT);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_filter_holds_off;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_sample && i_detect_enable && i_filter_enable && i_count >= 4'h2 && cnt == 4'h0 && !o_live)
            |=> !o_live;
    endproperty
    a_filter_holds_off: assert property (p_filter_holds_off) else $error("filter asserted too early");
endmodule

// *** hdl/hvl_fault_regs.sv ***
// Purpose: register bank for channel 2..3 pin function and led sink, and channel 1..3 fault status
// Assumes: registers reached over the 8-bit special-function-register port
// Notes: fault flags are sticky, cleared by writing zero to the flag bit
`timescale 1ns/1ps
module hvl_fault_regs (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [15:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    // detectors and pwm timing
    input wire logic i_pwm_mid,
    input wire logic [2:0] i_open_detect,
    input wire logic [2:0] i_short_detect,
    input wire logic [3:0] i_open_filter_count,
    input wire logic [3:0] i_short_filter_count,
    // pin configuration
    output logic [7:0] o_ch2_general_config,
    output logic [7:0] o_ch2_led_config,
    output logic [7:0] o_ch3_general_config,
    output logic [7:0] o_ch3_led_config,
    // detector enables and interrupt causes
    output logic [2:0] o_open_detect_enable,
    output logic [2:0] o_short_detect_enable,
    output logic [2:0] o_fault_irq
);
    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] fault_addr(input int ch);
        case (ch)
            0: fault_addr = hvl_pkg::ADDR_CH1_FAULT;
            1: fault_addr = hvl_pkg::ADDR_CH2_FAULT;
            default: fault_addr = hvl_pkg::ADDR_CH3_FAULT;
        endcase
    endfunction

    function automatic logic is_fault_addr(input logic [15:0] addr);
        is_fault_addr = (addr == hvl_pkg::ADDR_CH1_FAULT) || (addr == hvl_pkg::ADDR_CH2_FAULT)
            || (addr == hvl_pkg::ADDR_CH3_FAULT);
    endfunction

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] ch2_general_config;
    logic [7:0] ch2_led_config;
    logic [7:0] ch3_general_config;
    logic [7:0] ch3_led_config;
    logic [3:0] fault_ctrl [3];
    logic [2:0] open_flag;
    logic [2:0] short_flag;
    logic [2:0] open_live;
    logic [2:0] short_live;
    logic [2:0] open_set;
    logic [2:0] short_set;
    logic [2:0] fault_wr;
    logic [2:0] filter_en;
    logic [2:0] irq_en;
    logic [2:0] open_en;
    logic [2:0] short_en;
    logic [7:0] fault_view [3];
    logic [7:0] next_rdata;

    // ----------------------------------------------------------------
    // pin configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ch2_general_config <= hvl_pkg::GENERAL_RESET;
            ch3_general_config <= hvl_pkg::GENERAL_RESET;
        end else if (i_sfr_wr) begin
            if (i_sfr_addr == hvl_pkg::ADDR_CH2_GENERAL) begin
                ch2_general_config <= i_sfr_wdata;
            end
            if (i_sfr_addr == hvl_pkg::ADDR_CH3_GENERAL) begin
                ch3_general_config <= i_sfr_wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ch2_led_config <= hvl_pkg::LED_RESET;
            ch3_led_config <= hvl_pkg::LED_RESET;
        end else if (i_sfr_wr) begin
            if (i_sfr_addr == hvl_pkg::ADDR_CH2_LED) begin
                ch2_led_config <= i_sfr_wdata & hvl_pkg::CH2_LED_WMASK;
            end
            if (i_sfr_addr == hvl_pkg::ADDR_CH3_LED) begin
                ch3_led_config <= i_sfr_wdata & hvl_pkg::CH3_LED_WMASK;
            end
        end
    end

    assign o_ch2_general_config = ch2_general_config;
    assign o_ch2_led_config = ch2_led_config;
    assign o_ch3_general_config = ch3_general_config;
    assign o_ch3_led_config = ch3_led_config;

    // ----------------------------------------------------------------
    // per-channel fault logic
    // ----------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < hvl_pkg::NUM_CH; c++) begin : g_ch
            assign fault_wr[c] = i_sfr_wr && (i_sfr_addr == fault_addr(c));
            assign filter_en[c] = fault_ctrl[c][3];
            assign irq_en[c] = fault_ctrl[c][2];
            assign open_en[c] = fault_ctrl[c][1];
            assign short_en[c] = fault_ctrl[c][0];

            // control bits 7..4, live bits never written
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    fault_ctrl[c] <= hvl_pkg::FAULT_CTRL_RESET;
                end else if (fault_wr[c]) begin
                    fault_ctrl[c] <= i_sfr_wdata[hvl_pkg::FAULT_FILTER_BIT:hvl_pkg::FAULT_SHORT_EN_BIT];
                end
            end

            hvl_fault_filter u_open_filter (
                .i_sys_clk(i_sys_clk),
                .i_rst_n(i_rst_n),
                .i_sample(i_pwm_mid),
                .i_raw(i_open_detect[c]),
                .i_detect_enable(open_en[c]),
                .i_filter_enable(filter_en[c]),
                .i_count(i_open_filter_count),
                .o_live(open_live[c]),
                .o_set(open_set[c])
            );

            hvl_fault_filter u_short_filter (
                .i_sys_clk(i_sys_clk),
                .i_rst_n(i_rst_n),
                .i_sample(i_pwm_mid),
                .i_raw(i_short_detect[c]),
                .i_detect_enable(short_en[c]),
                .i_filter_enable(filter_en[c]),
                .i_count(i_short_filter_count),
                .o_live(short_live[c]),
                .o_set(short_set[c])
            );

            // sticky flags, set wins over software clear
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    open_flag[c] <= 1'b0;
                end else if (open_set[c]) begin
                    open_flag[c] <= 1'b1;
                end else if (fault_wr[c] && !i_sfr_wdata[hvl_pkg::FAULT_OPEN_FLAG_BIT]) begin
                    open_flag[c] <= 1'b0;
                end
            end

            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    short_flag[c] <= 1'b0;
                end else if (short_set[c]) begin
                    short_flag[c] <= 1'b1;
                end else if (fault_wr[c] && !i_sfr_wdata[hvl_pkg::FAULT_SHORT_FLAG_BIT]) begin
                    short_flag[c] <= 1'b0;
                end
            end

            // interrupt cause only while enabled
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_fault_irq[c] <= 1'b0;
                end else begin
                    o_fault_irq[c] <= irq_en[c] && (open_flag[c] || short_flag[c]);
                end
            end

            assign fault_view[c] = {fault_ctrl[c], open_live[c], short_live[c], open_flag[c], short_flag[c]};

            // checks
            property p_open_off;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                !open_en[c] ##1 !open_en[c] |-> !open_live[c];
            endproperty
            a_open_off: assert property (p_open_off) else $error("open status while detect off");

            property p_short_off;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                !short_en[c] ##1 !short_en[c] |-> !short_live[c];
            endproperty
            a_short_off: assert property (p_short_off) else $error("short status while detect off");

            property p_live_at_mid;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                !$past(i_pwm_mid) && $past(open_en[c]) && open_en[c] |-> $stable(open_live[c]);
            endproperty
            a_live_at_mid: assert property (p_live_at_mid) else $error("open status moved off mid");

            property p_short_irq;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                short_set[c] && irq_en[c] && !fault_wr[c] |=> short_flag[c] ##1 o_fault_irq[c];
            endproperty
            a_short_irq: assert property (p_short_irq) else $error("short fault raised no irq");

            property p_short_latch_quiet;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                short_set[c] && !irq_en[c] && !fault_wr[c] |=> short_flag[c] ##1 !o_fault_irq[c];
            endproperty
            a_short_latch_quiet: assert property (p_short_latch_quiet) else $error("short latch wrong");

            property p_short_sticky;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                short_flag[c] && !fault_wr[c] |=> short_flag[c];
            endproperty
            a_short_sticky: assert property (p_short_sticky) else $error("short flag dropped");

            property p_open_set;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                open_set[c] |=> open_flag[c];
            endproperty
            a_open_set: assert property (p_open_set) else $error("open flag not set");

            property p_open_sticky;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                open_flag[c] && !fault_wr[c] |=> open_flag[c];
            endproperty
            a_open_sticky: assert property (p_open_sticky) else $error("open flag dropped");

            property p_clear_by_zero;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                fault_wr[c] && !i_sfr_wdata[hvl_pkg::FAULT_OPEN_FLAG_BIT] && !open_set[c] |=> !open_flag[c];
            endproperty
            a_clear_by_zero: assert property (p_clear_by_zero) else $error("open flag not cleared");

            property p_short_at_mid;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                !$past(i_pwm_mid) && $past(short_en[c]) && short_en[c] |-> $stable(short_live[c]);
            endproperty
            a_short_at_mid: assert property (p_short_at_mid) else $error("short status moved off mid");

            property p_short_set;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                short_set[c] |=> short_flag[c];
            endproperty
            a_short_set: assert property (p_short_set) else $error("short flag not set");

            property p_short_clear;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                fault_wr[c] && !i_sfr_wdata[hvl_pkg::FAULT_SHORT_FLAG_BIT] && !short_set[c] |=> !short_flag[c];
            endproperty
            a_short_clear: assert property (p_short_clear) else $error("short flag not cleared");

            property p_open_irq;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                open_set[c] && irq_en[c] && !fault_wr[c] |=> open_flag[c] ##1 o_fault_irq[c];
            endproperty
            a_open_irq: assert property (p_open_irq) else $error("open fault raised no irq");

            property p_open_quiet;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                open_set[c] && !irq_en[c] && !fault_wr[c] |=> open_flag[c] ##1 !o_fault_irq[c];
            endproperty
            a_open_quiet: assert property (p_open_quiet) else $error("open latch wrong");

            property p_ctrl_write;
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                fault_wr[c] |=> fault_ctrl[c] == $past(i_sfr_wdata[hvl_pkg::FAULT_FILTER_BIT:hvl_pkg::FAULT_SHORT_EN_BIT]);
            endproperty
            a_ctrl_write: assert property (p_ctrl_write) else $error("fault control write wrong");

            c_open_flag: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) open_set[c] && irq_en[c]);
            c_short_flag: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) short_set[c]);
        end
    endgenerate

    assign o_open_detect_enable = open_en;
    assign o_short_detect_enable = short_en;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = hvl_pkg::RDATA_RESET;
        case (i_sfr_addr)
            hvl_pkg::ADDR_CH1_FAULT: next_rdata = fault_view[0];
            hvl_pkg::ADDR_CH2_FAULT: next_rdata = fault_view[1];
            hvl_pkg::ADDR_CH3_FAULT: next_rdata = fault_view[2];
            hvl_pkg::ADDR_CH2_GENERAL: next_rdata = ch2_general_config;
            hvl_pkg::ADDR_CH2_LED: next_rdata = ch2_led_config;
            hvl_pkg::ADDR_CH3_GENERAL: next_rdata = ch3_general_config;
            hvl_pkg::ADDR_CH3_LED: next_rdata = ch3_led_config;
            default: next_rdata = hvl_pkg::RDATA_RESET;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sfr_rdata <= hvl_pkg::RDATA_RESET;
        end else if (i_sfr_rd) begin
            o_sfr_rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // bank-level checks
    // ----------------------------------------------------------------
    property p_led_mask;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_sfr_wr && i_sfr_addr == hvl_pkg::ADDR_CH2_LED
            |=> o_ch2_led_config == ($past(i_sfr_wdata) & hvl_pkg::CH2_LED_WMASK);
    endproperty
    a_led_mask: assert property (p_led_mask) else $error("led config write wrong");

    property p_fault_read;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_sfr_rd && is_fault_addr(i_sfr_addr) && i_sfr_addr == hvl_pkg::ADDR_CH2_FAULT
            |=> o_sfr_rdata[hvl_pkg::FAULT_OPEN_LIVE_BIT] == $past(open_live[1]);
    endproperty
    a_fault_read: assert property (p_fault_read) else $error("live status read wrong");

    property p_led3_mask;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_sfr_wr && i_sfr_addr == hvl_pkg::ADDR_CH3_LED
            |=> o_ch3_led_config == ($past(i_sfr_wdata) & hvl_pkg::CH3_LED_WMASK);
    endproperty
    a_led3_mask: assert property (p_led3_mask) else $error("ch3 led config write wrong");

    property p_general_write;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_sfr_wr && i_sfr_addr == hvl_pkg::ADDR_CH2_GENERAL |=> o_ch2_general_config == $past(i_sfr_wdata);
    endproperty
    a_general_write: assert property (p_general_write) else $error("ch2 general config write wrong");

    c_clear_race: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) open_set[0] && fault_wr[0]);
    c_therm_on: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_ch3_led_config[hvl_pkg::LED_THERM_BIAS_BIT]);
endmodule

// *** hdl/hvl_pkg.sv ***
// Purpose: constants for the high-voltage channel fault and configuration register bank
// Assumes: 8-bit special-function-register bus, 16-bit byte addresses
// Notes: channel index 0..2 stands for channels 1..3
package hvl_pkg;
    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_CH1_FAULT = 16'hA046;
    localparam logic [15:0] ADDR_CH2_GENERAL = 16'hA048;
    localparam logic [15:0] ADDR_CH2_LED = 16'hA049;
    localparam logic [15:0] ADDR_CH2_FAULT = 16'hA04A;
    localparam logic [15:0] ADDR_CH3_GENERAL = 16'hA04C;
    localparam logic [15:0] ADDR_CH3_LED = 16'hA04D;
    localparam logic [15:0] ADDR_CH3_FAULT = 16'hA04E;

    // ----------------------------------------------------------------
    // fault register fields
    // ----------------------------------------------------------------
    localparam int NUM_CH = 3;
    localparam int FAULT_FILTER_BIT = 7;
    localparam int FAULT_IRQ_EN_BIT = 6;
    localparam int FAULT_OPEN_EN_BIT = 5;
    localparam int FAULT_SHORT_EN_BIT = 4;
    localparam int FAULT_OPEN_LIVE_BIT = 3;
    localparam int FAULT_SHORT_LIVE_BIT = 2;
    localparam int FAULT_OPEN_FLAG_BIT = 1;
    localparam int FAULT_SHORT_FLAG_BIT = 0;
    localparam logic [3:0] FAULT_CTRL_RESET = 4'h0;

    // ----------------------------------------------------------------
    // led configuration fields
    // ----------------------------------------------------------------
    localparam int LED_SINK_EN_BIT = 7;
    localparam int LED_THERM_BIAS_BIT = 5;
    localparam int LED_FS_MSB = 4;
    localparam int LED_FS_LSB = 0;
    localparam logic [7:0] CH2_LED_WMASK = 8'h9F;
    localparam logic [7:0] CH3_LED_WMASK = 8'hBF;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] GENERAL_RESET = 8'h00;
    localparam logic [7:0] LED_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [3:0] FILT_CNT_RESET = 4'h0;

    // ----------------------------------------------------------------
    // filter state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FLT_CLEAR = 2'b01,
        FLT_FAULT = 2'b10
    } hvl_filt_state_type;
endpackage
